// ---- rtl/pdi_pkg.sv ----
// constants, field layout and register map of the packet drop interrupt block
package pdi_pkg;

    localparam int ADDR_W = 16;
    localparam int DATA_W = 32;
    localparam int PEND_W = 14;

    // register indices; the byte address is four times the index
    localparam logic [15:0] IDX_MASK = 16'h1C20;
    localparam logic [15:0] IDX_PENDING = 16'h1C21;
    localparam logic [15:0] IDX_IRQ_STATUS = 16'h1C22;
    localparam logic [15:0] IDX_IRQ_CLEAR = 16'h1C23;
    localparam logic [15:0] IDX_IRQ_ENABLE = 16'h1C24;

    localparam logic [15:0] ADDR_MASK = {IDX_MASK[13:0], 2'h0};
    localparam logic [15:0] ADDR_PENDING = {IDX_PENDING[13:0], 2'h0};
    localparam logic [15:0] ADDR_IRQ_STATUS = {IDX_IRQ_STATUS[13:0], 2'h0};
    localparam logic [15:0] ADDR_IRQ_CLEAR = {IDX_IRQ_CLEAR[13:0], 2'h0};
    localparam logic [15:0] ADDR_IRQ_ENABLE = {IDX_IRQ_ENABLE[13:0], 2'h0};

    // pending register layout
    localparam int A_VALID_BIT = 0;
    localparam int A_PORT_LSB = 1;
    localparam int A_CAUSE_LSB = 3;
    localparam int B_VALID_BIT = 7;
    localparam int B_PORT_LSB = 8;
    localparam int B_CAUSE_LSB = 10;

    // mask register layout and reset value
    localparam int MASK_BIT = 0;
    localparam logic MASK_RST = 1'h1;

    // event status bits
    localparam int EV_CAPTURE = 0;
    localparam int EV_DISCARD = 1;
    localparam int EV_W = 2;
    localparam logic [1:0] EV_ENABLE_RST = 2'h0;

    // drop cause codes
    localparam logic [3:0] CAUSE_BCAST_LEVEL = 4'h0;
    localparam logic [3:0] CAUSE_RED = 4'h1;
    localparam logic [3:0] CAUSE_NO_BUFFER = 4'h2;
    localparam logic [3:0] CAUSE_NO_DESCRIPTOR = 4'h3;
    localparam logic [3:0] CAUSE_NO_DEST_PORT = 4'h4;
    localparam logic [3:0] CAUSE_RX_ERROR = 4'h5;
    localparam logic [3:0] CAUSE_DROP_LEVEL = 4'h6;
    localparam logic [3:0] CAUSE_YELLOW = 4'h9;

    // source port codes
    localparam logic [1:0] PORT_0 = 2'h0;
    localparam logic [1:0] PORT_1 = 2'h1;
    localparam logic [1:0] PORT_2 = 2'h2;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : pdi_pkg

// ---- rtl/pdi_slot_store.sv ----
// two capture slots for drop events, cleared by a pending register read
`timescale 1ns/1ns
module pdi_slot_store (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic drop_valid,
    input wire logic [3:0] drop_cause,
    input wire logic [1:0] drop_port,
    input wire logic read_clear,
    output logic [pdi_pkg::PEND_W-1:0] pending,
    output logic captured,
    output logic discarded
);

    typedef struct packed {
        logic a_valid;
        logic [3:0] a_cause;
        logic [1:0] a_port;
        logic b_valid;
        logic [3:0] b_cause;
        logic [1:0] b_port;
        logic captured;
        logic discarded;
    } pdi_slot_state_type;

    pdi_slot_state_type st_ff;
    pdi_slot_state_type nxt_st;

    always_comb begin
        nxt_st = st_ff;
        nxt_st.captured = 1'h0;
        nxt_st.discarded = 1'h0;
        if (read_clear) begin
            nxt_st.a_valid = 1'h0;
            nxt_st.a_cause = 4'h0;
            nxt_st.a_port = 2'h0;
            nxt_st.b_valid = 1'h0;
            nxt_st.b_cause = 4'h0;
            nxt_st.b_port = 2'h0;
        end
        // decided after the clear, so an event in the read cycle is kept
        if (drop_valid) begin
            if (!nxt_st.a_valid) begin
                nxt_st.a_valid = 1'h1;
                nxt_st.a_cause = drop_cause;
                nxt_st.a_port = drop_port;
                nxt_st.captured = 1'h1;
            end else if (!nxt_st.b_valid) begin
                nxt_st.b_valid = 1'h1;
                nxt_st.b_cause = drop_cause;
                nxt_st.b_port = drop_port;
                nxt_st.captured = 1'h1;
            end else begin
                nxt_st.discarded = 1'h1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign pending = {st_ff.b_cause, st_ff.b_port, st_ff.b_valid, st_ff.a_cause, st_ff.a_port, st_ff.a_valid};
    assign captured = st_ff.captured;
    assign discarded = st_ff.discarded;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_event_a_free;
        drop_valid && !read_clear && !st_ff.a_valid;
    endsequence

    sequence s_event_b_free;
        drop_valid && !read_clear && st_ff.a_valid && !st_ff.b_valid;
    endsequence

    a_fill_slot_a: assert property (s_event_a_free |=> st_ff.a_valid && st_ff.a_cause == $past(drop_cause)
        && st_ff.a_port == $past(drop_port) && st_ff.b_valid == $past(st_ff.b_valid))
        else $error("slot a not filled by event");
    a_fill_slot_b: assert property (s_event_b_free |=> st_ff.b_valid && st_ff.b_cause == $past(drop_cause)
        && st_ff.b_port == $past(drop_port) && st_ff.a_cause == $past(st_ff.a_cause))
        else $error("slot b not filled by event");
    a_discard_full: assert property (drop_valid && !read_clear && st_ff.a_valid && st_ff.b_valid
        |=> discarded && $stable(pending))
        else $error("event while full changed slots");
    a_clear_read: assert property (read_clear && !drop_valid |=> pending == '0 ##1 pending == '0 || captured)
        else $error("pending not cleared by read");

endmodule : pdi_slot_store

// ---- rtl/pdi_drop_irq.sv ----
// packet drop interrupt block: axi4-lite registers, mask, event status, capture slots
// Summary of operation
// - mask bit 0 resets to one; while set the interrupt output stays low.
// - writing mask bit to zero lets pending drop status raise the interrupt.
// - drop status is captured whatever the mask; mask only gates the output.
// - two capture slots A and B hold two drop events; B fills only while A is occupied.
// - slot A valid at bit 0, resets zero, cleared by reading.
// - slot A cause in bits 6:3, same coding as B, cleared by reading.
// - slot A source port in bits 2:1, ports 0 to 2, cleared by reading.
// - slot B pending flag at bit 7, resets zero, cleared by reading.
// - slot B cause in bits 13:10, port in bits 9:8, cleared by reading.
// - cause codes 0 to 3: broadcast level, red, no buffers, no descriptors.
// - codes 4,5,6,9: no dest port, rx error, drop level, yellow; rest reserved.
//
// Our own choice: register access over AXI4-Lite.
`timescale 1ns/1ns
module pdi_drop_irq (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic drop_valid,
    input wire logic [3:0] drop_cause,
    input wire logic [1:0] drop_port,
    input wire logic [pdi_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [pdi_pkg::DATA_W-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [pdi_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [pdi_pkg::DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic irq
);

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [pdi_pkg::DATA_W-1:0] rdata;
        logic aw_have;
        logic [pdi_pkg::ADDR_W-1:0] aw_addr;
        logic w_have;
        logic [pdi_pkg::DATA_W-1:0] w_data;
        logic [3:0] w_strb;
        logic mask;
        logic [pdi_pkg::EV_W-1:0] ev_status;
        logic [pdi_pkg::EV_W-1:0] ev_enable;
        logic irq;
    } pdi_top_state_type;

    pdi_top_state_type st_ff;
    pdi_top_state_type nxt_st;

    logic [pdi_pkg::PEND_W-1:0] pending;
    logic captured;
    logic discarded;
    logic rd_take;
    logic rd_clear;
    logic wr_do;
    logic slot_any;

    // the clear travels with the read that returns the snapshot, so no event is lost in between
    assign rd_take = s_axi_arvalid && st_ff.arready;
    assign rd_clear = rd_take && (s_axi_araddr == pdi_pkg::ADDR_PENDING);
    assign wr_do = st_ff.aw_have && st_ff.w_have && !st_ff.bvalid;
    assign slot_any = pending[pdi_pkg::A_VALID_BIT] || pending[pdi_pkg::B_VALID_BIT];

    pdi_slot_store u_slots (
        .aclk(aclk),
        .aresetn(aresetn),
        .drop_valid(drop_valid),
        .drop_cause(drop_cause),
        .drop_port(drop_port),
        .read_clear(rd_clear),
        .pending(pending),
        .captured(captured),
        .discarded(discarded)
    );

    always_comb begin
        nxt_st = st_ff;

        // write address and data are taken in either order and held until both are present
        if (s_axi_awvalid && st_ff.awready) begin
            nxt_st.aw_have = 1'h1;
            nxt_st.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && st_ff.wready) begin
            nxt_st.w_have = 1'h1;
            nxt_st.w_data = s_axi_wdata;
            nxt_st.w_strb = s_axi_wstrb;
        end

        if (st_ff.bvalid && s_axi_bready) begin
            nxt_st.bvalid = 1'h0;
        end

        if (wr_do) begin
            nxt_st.aw_have = 1'h0;
            nxt_st.w_have = 1'h0;
            nxt_st.bvalid = 1'h1;
            nxt_st.bresp = pdi_pkg::RESP_OKAY;
            unique case (st_ff.aw_addr)
                pdi_pkg::ADDR_MASK: begin
                    if (st_ff.w_strb[0]) begin
                        nxt_st.mask = st_ff.w_data[pdi_pkg::MASK_BIT];
                    end
                end
                pdi_pkg::ADDR_IRQ_CLEAR: begin
                    if (st_ff.w_strb[0]) begin
                        nxt_st.ev_status = st_ff.ev_status & ~st_ff.w_data[pdi_pkg::EV_W-1:0];
                    end
                end
                pdi_pkg::ADDR_IRQ_ENABLE: begin
                    if (st_ff.w_strb[0]) begin
                        nxt_st.ev_enable = st_ff.w_data[pdi_pkg::EV_W-1:0];
                    end
                end
                pdi_pkg::ADDR_PENDING, pdi_pkg::ADDR_IRQ_STATUS: begin
                    // read-only: the write is answered and has no effect
                    nxt_st.bresp = pdi_pkg::RESP_OKAY;
                end
                default: begin
                    nxt_st.bresp = pdi_pkg::RESP_SLVERR;
                end
            endcase
        end

        // a set arriving with a clear wins, since it is applied last
        if (captured) begin
            nxt_st.ev_status[pdi_pkg::EV_CAPTURE] = 1'h1;
        end
        if (discarded) begin
            nxt_st.ev_status[pdi_pkg::EV_DISCARD] = 1'h1;
        end

        if (st_ff.rvalid && s_axi_rready) begin
            nxt_st.rvalid = 1'h0;
        end

        if (rd_take) begin
            nxt_st.rvalid = 1'h1;
            nxt_st.rresp = pdi_pkg::RESP_OKAY;
            nxt_st.rdata = '0;
            unique case (s_axi_araddr)
                pdi_pkg::ADDR_MASK: begin
                    nxt_st.rdata[pdi_pkg::MASK_BIT] = st_ff.mask;
                end
                pdi_pkg::ADDR_PENDING: begin
                    nxt_st.rdata[pdi_pkg::PEND_W-1:0] = pending;
                end
                pdi_pkg::ADDR_IRQ_STATUS: begin
                    nxt_st.rdata[pdi_pkg::EV_W-1:0] = st_ff.ev_status;
                end
                pdi_pkg::ADDR_IRQ_ENABLE: begin
                    nxt_st.rdata[pdi_pkg::EV_W-1:0] = st_ff.ev_enable;
                end
                pdi_pkg::ADDR_IRQ_CLEAR: begin
                    // write-only: reads as zero
                    nxt_st.rdata = '0;
                end
                default: begin
                    nxt_st.rresp = pdi_pkg::RESP_SLVERR;
                end
            endcase
        end

        // one write and one read at a time keeps the slave free of queues
        nxt_st.awready = !nxt_st.aw_have && !nxt_st.bvalid;
        nxt_st.wready = !nxt_st.w_have && !nxt_st.bvalid;
        nxt_st.arready = !nxt_st.rvalid;

        // mask suppresses only the output, the slots and status keep recording
        nxt_st.irq = !st_ff.mask && (slot_any || (|(st_ff.ev_status & st_ff.ev_enable)));
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_ff <= '0;
            st_ff.mask <= pdi_pkg::MASK_RST;
            st_ff.ev_enable <= pdi_pkg::EV_ENABLE_RST;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign s_axi_awready = st_ff.awready;
    assign s_axi_wready = st_ff.wready;
    assign s_axi_bvalid = st_ff.bvalid;
    assign s_axi_bresp = st_ff.bresp;
    assign s_axi_arready = st_ff.arready;
    assign s_axi_rvalid = st_ff.rvalid;
    assign s_axi_rresp = st_ff.rresp;
    assign s_axi_rdata = st_ff.rdata;
    assign irq = st_ff.irq;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_write_go;
        wr_do;
    endsequence

    sequence s_mask_write;
        wr_do && st_ff.aw_addr == pdi_pkg::ADDR_MASK && st_ff.w_strb[0];
    endsequence

    sequence s_mask_read;
        rd_take && s_axi_araddr == pdi_pkg::ADDR_MASK;
    endsequence

    property p_write_answer;
        s_write_go |=> st_ff.bvalid && !st_ff.awready && !st_ff.wready;
    endproperty

    a_mask_reset_value: assert property (!$past(aresetn) |-> st_ff.mask && !st_ff.irq)
        else $error("mask not set after reset");
    a_mask_blocks_irq: assert property (st_ff.mask |=> !st_ff.irq)
        else $error("interrupt while masked");
    a_unmask_irq: assert property (!st_ff.mask && slot_any |=> st_ff.irq)
        else $error("unmasked pending drop gave no interrupt");
    a_mask_write_taken: assert property (s_mask_write |=> st_ff.mask == $past(st_ff.w_data[0]))
        else $error("mask write not applied");
    a_masked_capture: assert property (st_ff.mask && drop_valid && !rd_clear && !wr_do
        && !pending[pdi_pkg::A_VALID_BIT] |=> pending[pdi_pkg::A_VALID_BIT] ##1 !st_ff.irq)
        else $error("capture lost while masked");
    a_write_answer: assert property (p_write_answer)
        else $error("write not answered");
    a_mask_readback: assert property (s_mask_read |=> st_ff.rvalid && st_ff.rdata == {31'h0, $past(st_ff.mask)})
        else $error("mask readback wrong");
    a_event_sticky: assert property (captured |=> st_ff.ev_status[pdi_pkg::EV_CAPTURE])
        else $error("capture event not recorded");

    // slot fields are checked through the pending word, the same view that software reads
    sequence s_pending_read;
        rd_take && s_axi_araddr == pdi_pkg::ADDR_PENDING;
    endsequence

    sequence s_clear_write;
        wr_do && st_ff.aw_addr == pdi_pkg::ADDR_IRQ_CLEAR && st_ff.w_strb[0];
    endsequence

    sequence s_slot_a_free;
        drop_valid && !rd_clear && !pending[pdi_pkg::A_VALID_BIT];
    endsequence

    sequence s_slot_b_free;
        drop_valid && !rd_clear && pending[pdi_pkg::A_VALID_BIT] && !pending[pdi_pkg::B_VALID_BIT];
    endsequence

    sequence s_slot_a_busy;
        pending[pdi_pkg::A_VALID_BIT] && !rd_clear;
    endsequence

    sequence s_both_busy;
        pending[pdi_pkg::A_VALID_BIT] && pending[pdi_pkg::B_VALID_BIT] && !rd_clear;
    endsequence

    a_pending_snapshot: assert property (s_pending_read
        |=> st_ff.rvalid && st_ff.rdata == {18'h0, $past(pending)})
        else $error("pending read returned a wrong snapshot");

    a_pending_cleared: assert property (s_pending_read ##0 !drop_valid
        |=> pending == '0)
        else $error("pending read left a slot set");

    a_clear_keeps_event: assert property (s_pending_read ##0 drop_valid
        |=> pending[pdi_pkg::A_VALID_BIT] && !pending[pdi_pkg::B_VALID_BIT]
        && pending[pdi_pkg::A_CAUSE_LSB +: 4] == $past(drop_cause))
        else $error("event on the clearing edge lost");

    a_b_needs_a: assert property (pending[pdi_pkg::B_VALID_BIT]
        |-> pending[pdi_pkg::A_VALID_BIT])
        else $error("slot b set while slot a empty");

    a_empty_a_fields: assert property (!pending[pdi_pkg::A_VALID_BIT]
        |-> pending[pdi_pkg::B_VALID_BIT-1:pdi_pkg::A_PORT_LSB] == 6'h0)
        else $error("slot a fields set while empty");

    a_empty_b_fields: assert property (!pending[pdi_pkg::B_VALID_BIT]
        |-> pending[pdi_pkg::B_PORT_LSB +: 6] == 6'h0)
        else $error("slot b fields set while empty");

    a_slot_a_holds: assert property (s_slot_a_busy
        |=> $stable(pending[pdi_pkg::B_VALID_BIT-1:0]))
        else $error("slot a changed while occupied");

    a_full_slots_hold: assert property (s_both_busy
        |=> $stable(pending))
        else $error("full slots changed without a read");

    a_full_discards: assert property (s_both_busy ##0 drop_valid
        |=> discarded && !captured)
        else $error("event while full not discarded");

    a_discard_sticky: assert property (discarded
        |=> st_ff.ev_status[pdi_pkg::EV_DISCARD])
        else $error("discard event not recorded");

    a_status_clear: assert property (s_clear_write ##0 !captured && !discarded
        |=> (st_ff.ev_status & $past(st_ff.w_data[pdi_pkg::EV_W-1:0])) == '0)
        else $error("event status not cleared");

    a_status_irq: assert property (!st_ff.mask && |(st_ff.ev_status & st_ff.ev_enable)
        |=> st_ff.irq)
        else $error("enabled event gave no interrupt");

    a_no_cause_quiet: assert property (!slot_any && !(|(st_ff.ev_status & st_ff.ev_enable))
        |=> !st_ff.irq)
        else $error("interrupt without a cause");

    a_mask_only_written: assert property (!wr_do
        |=> $stable(st_ff.mask))
        else $error("mask changed without a write");

    a_masked_fill: assert property (st_ff.mask && drop_valid && !pending[pdi_pkg::B_VALID_BIT]
        |=> captured)
        else $error("masked event not captured");

    a_reset_idle: assert property (!$past(aresetn)
        |-> !st_ff.bvalid && !st_ff.rvalid && pending == '0 && st_ff.ev_status == '0)
        else $error("state not idle after reset");

    a_mask_write_okay: assert property (s_mask_write
        |=> st_ff.bvalid && st_ff.bresp == pdi_pkg::RESP_OKAY)
        else $error("mask write not answered okay");

    a_enable_write: assert property (wr_do && st_ff.aw_addr == pdi_pkg::ADDR_IRQ_ENABLE && st_ff.w_strb[0]
        |=> st_ff.ev_enable == $past(st_ff.w_data[pdi_pkg::EV_W-1:0]))
        else $error("enable write not applied");

    a_fill_a_port: assert property (s_slot_a_free
        |=> pending[pdi_pkg::A_PORT_LSB +: 2] == $past(drop_port))
        else $error("slot a port wrong");

    a_fill_a_cause: assert property (s_slot_a_free
        |=> pending[pdi_pkg::A_CAUSE_LSB +: 4] == $past(drop_cause))
        else $error("slot a cause wrong");

    a_fill_b_port: assert property (s_slot_b_free
        |=> pending[pdi_pkg::B_PORT_LSB +: 2] == $past(drop_port))
        else $error("slot b port wrong");

    a_fill_b_cause: assert property (s_slot_b_free
        |=> pending[pdi_pkg::B_CAUSE_LSB +: 4] == $past(drop_cause))
        else $error("slot b cause wrong");

endmodule : pdi_drop_irq

// ---- tb/pdi_testbench.sv ----
// self-checking bench for the packet drop interrupt block with a register-level model
`timescale 1ns/1ns
module testbench;
    logic aclk;
    logic aresetn;
    logic drop_valid;
    logic [3:0] drop_cause;
    logic [1:0] drop_port;
    logic [15:0] s_axi_awaddr;
    logic s_axi_awvalid;
    logic s_axi_awready;
    logic [31:0] s_axi_wdata;
    logic [3:0] s_axi_wstrb;
    logic s_axi_wvalid;
    logic s_axi_wready;
    logic [1:0] s_axi_bresp;
    logic s_axi_bvalid;
    logic s_axi_bready;
    logic [15:0] s_axi_araddr;
    logic s_axi_arvalid;
    logic s_axi_arready;
    logic [31:0] s_axi_rdata;
    logic [1:0] s_axi_rresp;
    logic s_axi_rvalid;
    logic s_axi_rready;
    logic irq;
    int fails;
    int comparisons;
    int mdl_pend;
    int mdl_status;
    int mdl_en;
    int mdl_mask;
    int snap;
    int causes[$];
    logic [31:0] rd;
    logic [1:0] rsp;

    pdi_drop_irq uut (.aclk(aclk), .aresetn(aresetn), .drop_valid(drop_valid), .drop_cause(drop_cause),
        .drop_port(drop_port), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .irq(irq));

    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end

    task automatic complete_run();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : complete_run

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // outputs are registered, so sampling in the edge's active region sees the pre-edge value
    task automatic axi_write(input logic [15:0] addr, input logic [31:0] data, output logic [1:0] resp);
        int n;
        n = 0;
        @(posedge aclk);
        s_axi_awaddr <= addr;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= data;
        s_axi_wstrb <= 4'hF;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        forever begin
            @(posedge aclk);
            n++;
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid || n > 100) break;
        end
        if (n > 100) fails++;
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask : axi_write

    task automatic axi_read(input logic [15:0] addr, output logic [31:0] data, output logic [1:0] resp);
        int n;
        n = 0;
        @(posedge aclk);
        s_axi_araddr <= addr;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        forever begin
            @(posedge aclk);
            n++;
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid || n > 100) break;
        end
        if (n > 100) fails++;
        data = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask : axi_read

    task automatic wr(input logic [15:0] addr, input logic [31:0] data);
        axi_write(addr, data, rsp);
        check(32'(rsp), 32'(pdi_pkg::RESP_OKAY));
        if (addr == pdi_pkg::ADDR_MASK) mdl_mask = int'(data[0]);
        if (addr == pdi_pkg::ADDR_IRQ_ENABLE) mdl_en = int'(data[1:0]);
        if (addr == pdi_pkg::ADDR_IRQ_CLEAR) mdl_status = mdl_status & ~int'(data[1:0]);
    endtask : wr

    task automatic rd_pending();
        axi_read(pdi_pkg::ADDR_PENDING, rd, rsp);
        check(rd, 32'(mdl_pend));
        mdl_pend = 0;
    endtask : rd_pending

    // one-cycle drop pulse; model fills A, then B, otherwise sets the discard status bit
    task automatic drop(input int cause, input int port);
        @(posedge aclk);
        drop_valid <= 1'b1;
        drop_cause <= 4'(cause);
        drop_port <= 2'(port);
        @(posedge aclk);
        drop_valid <= 1'b0;
        if ((mdl_pend & 1) == 0) begin
            mdl_pend = mdl_pend | 1 | (port << 1) | (cause << 3);
            mdl_status = mdl_status | 1;
        end else if ((mdl_pend & 128) == 0) begin
            mdl_pend = mdl_pend | 128 | (port << 8) | (cause << 10);
            mdl_status = mdl_status | 1;
        end else begin
            mdl_status = mdl_status | 2;
        end
    endtask : drop

    // irq lags its causes by a few cycles, so let them settle before sampling
    task automatic check_irq();
        logic exp;
        repeat (4) @(posedge aclk);
        exp = (mdl_mask == 0) && ((mdl_pend & 129) != 0 || (mdl_status & mdl_en) != 0);
        check(32'(irq), 32'(exp));
    endtask : check_irq

    initial begin
        #200000;
        fails++;
        complete_run();
    end

    initial begin
        aresetn = 1'b0;
        drop_valid = 1'b0;
        drop_cause = 4'h0;
        drop_port = 2'h0;
        s_axi_awaddr = 16'h0000;
        s_axi_awvalid = 1'b0;
        s_axi_wdata = 32'h00000000;
        s_axi_wstrb = 4'h0;
        s_axi_wvalid = 1'b0;
        s_axi_bready = 1'b0;
        s_axi_araddr = 16'h0000;
        s_axi_arvalid = 1'b0;
        s_axi_rready = 1'b0;
        fails = 0;
        comparisons = 0;
        mdl_pend = 0;
        mdl_status = 0;
        mdl_en = 0;
        mdl_mask = 1;
        causes = '{0, 1, 2, 3, 4, 5, 6, 9};
        void'($urandom(10));
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        axi_read(pdi_pkg::ADDR_MASK, rd, rsp);
        check(rd, 32'h00000001);
        rd_pending();
        check_irq();
        // masked capture: status kept, interrupt held off
        drop(int'(pdi_pkg::CAUSE_RED), int'(pdi_pkg::PORT_1));
        check_irq();
        rd_pending();
        rd_pending();
        wr(pdi_pkg::ADDR_MASK, 32'hFFFFFFFE);
        axi_read(pdi_pkg::ADDR_MASK, rd, rsp);
        check(rd, 32'h00000000);
        for (int i = 0; i < causes.size(); i++) begin
            drop(causes[i], int'($urandom_range(2, 0)));
            check_irq();
            drop(causes[(i + 1) % causes.size()], int'($urandom_range(2, 0)));
            drop(causes[i], int'($urandom_range(2, 0)));
            check_irq();
            rd_pending();
            check_irq();
        end
        // event status, enable and clear; both event kinds are set by now
        axi_read(pdi_pkg::ADDR_IRQ_STATUS, rd, rsp);
        check(rd, 32'(mdl_status));
        wr(pdi_pkg::ADDR_IRQ_ENABLE, 32'h00000003);
        axi_read(pdi_pkg::ADDR_IRQ_ENABLE, rd, rsp);
        check(rd, 32'h00000003);
        check_irq();
        wr(pdi_pkg::ADDR_IRQ_CLEAR, 32'h00000001);
        check_irq();
        wr(pdi_pkg::ADDR_IRQ_CLEAR, 32'h00000002);
        axi_read(pdi_pkg::ADDR_IRQ_STATUS, rd, rsp);
        check(rd, 32'(mdl_status));
        check_irq();
        // re-masking suppresses a fresh capture without losing it
        wr(pdi_pkg::ADDR_MASK, 32'h00000001);
        drop(int'(pdi_pkg::CAUSE_YELLOW), int'(pdi_pkg::PORT_2));
        check_irq();
        rd_pending();
        // an event on the clearing edge goes to slot A; the read returns the older snapshot
        drop(int'(pdi_pkg::CAUSE_NO_BUFFER), 3);
        snap = mdl_pend;
        mdl_pend = 0;
        fork
            axi_read(pdi_pkg::ADDR_PENDING, rd, rsp);
            drop(int'(pdi_pkg::CAUSE_RX_ERROR), int'(pdi_pkg::PORT_0));
        join
        check(rd, 32'(snap));
        wr(pdi_pkg::ADDR_PENDING, 32'h00003FFF);
        rd_pending();
        axi_read(pdi_pkg::ADDR_IRQ_CLEAR, rd, rsp);
        check(rd, 32'h00000000);
        axi_read(16'h0000, rd, rsp);
        check(32'(rsp), 32'(pdi_pkg::RESP_SLVERR));
        check(rd, 32'h00000000);
        axi_write(16'h0010, 32'h00000001, rsp);
        check(32'(rsp), 32'(pdi_pkg::RESP_SLVERR));
        complete_run();
    end
endmodule : testbench
